// [pkg/dsp_pkg.sv]
// package of constants and carrier types for the dual serial port block
package dsp_pkg;

	// ----------------------------------------------------------------
	// clock and timing
	// ----------------------------------------------------------------
	localparam int unsigned CLK_HZ          = 25000000;
	localparam int unsigned DEF_BAUD        = 4800;
	localparam int unsigned DEF_BAUD_DIV    = CLK_HZ / DEF_BAUD;
	localparam int unsigned OVS             = 16;
	localparam logic [15:0] DEF_OVS_DIV     = 16'(CLK_HZ / (DEF_BAUD * OVS));
	localparam int unsigned DRV_EN_DLY_NS   = 1000;
	localparam logic [7:0]  DRV_EN_DLY_CYC  = 8'((DRV_EN_DLY_NS * 25 + 999) / 1000);

	// ----------------------------------------------------------------
	// data path
	// ----------------------------------------------------------------
	localparam int unsigned FIFO_DEPTH      = 32;
	localparam int unsigned FIFO_AW         = 5;
	localparam logic [5:0]  NEAR_FULL_LVL   = 6'd24;
	localparam logic [5:0]  RESUME_LVL      = 6'd8;
	localparam logic [7:0]  CODE_STOP       = 8'h13;
	localparam logic [7:0]  CODE_RESUME     = 8'h11;

	// ----------------------------------------------------------------
	// line characteristic switch fields (per port bank of eight)
	// ----------------------------------------------------------------
	localparam int unsigned SW_BAUD_LSB     = 0;
	localparam int unsigned SW_DBITS_BIT    = 4;
	localparam int unsigned SW_PAR_LSB      = 5;
	localparam int unsigned SW_STOP_BIT     = 7;
	localparam logic [7:0]  LINE_SW_DEFAULT = 8'hab; // 4800 baud, 7 bits, no parity, 2 stop

	// ----------------------------------------------------------------
	// flow switch bank fields: even port low half, odd port high half
	// ----------------------------------------------------------------
	localparam int unsigned FSW_EN_BIT      = 0;
	localparam int unsigned FSW_POL_BIT     = 1;
	localparam int unsigned FSW_PORT_STRIDE = 4;
	localparam logic [7:0]  FLOW_SW_DEFAULT = 8'h00;

	typedef enum logic [1:0] {
		DSP_IF_SINGLE,
		DSP_IF_DIFF,
		DSP_IF_LOOP
	} dsp_if_e;

	// line setting as used by one port
	typedef struct packed {
		logic [15:0] ovs_div;
		logic        eight_bits;
		logic        par_en;
		logic        par_odd;
		logic        two_stop;
	} dsp_line_s;

	// modem control pins of one port
	typedef struct packed {
		logic cts;
		logic sec_detect;
	} dsp_modem_in_s;

	// divider per baud code 0..15, 16x oversample
	function automatic logic [15:0] dsp_baud_div(input logic [3:0] code);
		int unsigned b;
		case (code)
			4'h0: b = 75;
			4'h1: b = 110;
			4'h2: b = 134;
			4'h3: b = 150;
			4'h4: b = 300;
			4'h5: b = 600;
			4'h6: b = 1200;
			4'h7: b = 1800;
			4'h8: b = 2000;
			4'h9: b = 2400;
			4'ha: b = 3600;
			4'hb: b = 4800;
			4'hc: b = 7200;
			4'hd: b = 9600;
			default: b = 19200;
		endcase
		return 16'(CLK_HZ / (b * OVS));
	endfunction

endpackage

// [design/dsp_fifo.sv]
// synchronous valid/ready fifo with flip-flop storage
`timescale 1ns/1ps
module dsp_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32,
	parameter int unsigned AW    = 5
) (
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	output logic      [WIDTH-1:0] out_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [AW:0]      level
);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      cnt_reg;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_reg != AW'(0) + (AW+1)'(DEPTH));
	assign out_valid = (cnt_reg != '0);
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_reg[rd_ptr_reg];
	assign level     = cnt_reg;

	// storage write, no reset needed on data
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_reg[wr_ptr_reg] <= in_data;
		end
	end

	// pointers and occupancy
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg    <= '0;
		end else begin
			if (push) begin
				wr_ptr_reg <= wr_ptr_reg + AW'(1);
			end
			if (pop) begin
				rd_ptr_reg <= rd_ptr_reg + AW'(1);
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// [design/dsp_uart.sv]
// one asynchronous serial engine: 16x oversampled receiver and transmitter
`timescale 1ns/1ps
module dsp_uart (
	input  wire logic             mclk,
	input  wire logic             srst,
	input  wire dsp_pkg::dsp_line_s line,
	input  wire logic             rxd,
	output logic                  txd_reg,
	input  wire logic             tx_allow,
	input  wire logic [7:0]       tx_data,
	input  wire logic             tx_valid,
	output logic                  tx_ready,
	output logic [7:0]            rx_data_reg,
	output logic                  rx_strobe_reg
);
	import dsp_pkg::*;

	// ----------------------------------------------------------------
	// oversample tick
	// ----------------------------------------------------------------
	logic [15:0] div_cnt_reg;
	logic        tick;

	assign tick = (div_cnt_reg == 16'h0000);

	// one enable pulse per sixteenth of a bit
	always_ff @(posedge mclk) begin
		if (srst || tick) begin
			div_cnt_reg <= line.ovs_div - 16'h0001;
		end else begin
			div_cnt_reg <= div_cnt_reg - 16'h0001;
		end
	end

	// ----------------------------------------------------------------
	// transmitter
	// ----------------------------------------------------------------
	logic [10:0] tx_sh_reg;
	logic [3:0]  tx_bits_reg;
	logic [3:0]  tx_ph_reg;
	logic        tx_busy_reg;
	logic        par_bit;
	logic [3:0]  frame_len;

	assign par_bit   = line.eight_bits ? (^tx_data) ^ line.par_odd
	                                   : (^tx_data[6:0]) ^ line.par_odd;
	assign frame_len = 4'(1 + (line.eight_bits ? 8 : 7) + (line.par_en ? 1 : 0)
	                      + (line.two_stop ? 2 : 1));
	// a frame only starts between characters, so cts drops take effect on the boundary
	assign tx_ready  = !tx_busy_reg && tx_allow;

	always_ff @(posedge mclk) begin
		if (srst) begin
			txd_reg     <= 1'b1;
			tx_busy_reg <= 1'b0;
			tx_sh_reg   <= '1;
			tx_bits_reg <= '0;
			tx_ph_reg   <= '0;
		end else if (tx_valid && tx_ready) begin
			tx_busy_reg <= 1'b1;
			tx_bits_reg <= frame_len;
			tx_ph_reg   <= '0;
			txd_reg     <= 1'b0;
			if (line.eight_bits) begin
				tx_sh_reg <= {1'b1, line.par_en ? par_bit : 1'b1, tx_data, 1'b0};
			end else begin
				tx_sh_reg <= {2'b11, line.par_en ? par_bit : 1'b1, tx_data[6:0], 1'b0};
			end
		end else if (tx_busy_reg && tick) begin
			tx_ph_reg <= tx_ph_reg + 4'h1;
			if (tx_ph_reg == 4'hf) begin
				if (tx_bits_reg == 4'h1) begin
					tx_busy_reg <= 1'b0;
					txd_reg     <= 1'b1;
				end else begin
					tx_sh_reg   <= {1'b1, tx_sh_reg[10:1]};
					txd_reg     <= tx_sh_reg[1];
				end
				tx_bits_reg <= tx_bits_reg - 4'h1;
			end
		end
	end

	// ----------------------------------------------------------------
	// receiver: samples mid-bit, drops frames with a low stop bit
	// ----------------------------------------------------------------
	logic       rx_busy_reg;
	logic [3:0] rx_ph_reg;
	logic [3:0] rx_bits_reg;
	logic [8:0] rx_sh_reg;
	logic [3:0] rx_need;

	assign rx_need = 4'((line.eight_bits ? 8 : 7) + (line.par_en ? 1 : 0) + 1);

	always_ff @(posedge mclk) begin
		if (srst) begin
			rx_busy_reg   <= 1'b0;
			rx_ph_reg     <= '0;
			rx_bits_reg   <= '0;
			rx_sh_reg     <= '0;
			rx_data_reg   <= '0;
			rx_strobe_reg <= 1'b0;
		end else begin
			rx_strobe_reg <= 1'b0;
			if (tick) begin
				if (!rx_busy_reg) begin
					if (!rxd) begin
						rx_busy_reg <= 1'b1;
						rx_ph_reg   <= 4'h1;
						rx_bits_reg <= '0;
					end
				end else begin
					rx_ph_reg <= rx_ph_reg + 4'h1;
					if (rx_ph_reg == 4'h7) begin
						if (rx_bits_reg == 4'h0 && rxd) begin
							rx_busy_reg <= 1'b0;
						end else if (rx_bits_reg == rx_need) begin
							rx_busy_reg   <= 1'b0;
							rx_strobe_reg <= rxd;
							rx_data_reg   <= line.eight_bits ? rx_sh_reg[8:1]
							                 : {1'b0, rx_sh_reg[8:2]};
						end else begin
							rx_bits_reg <= rx_bits_reg + 4'h1;
							if (rx_bits_reg != 4'h0 &&
							    !(line.par_en && rx_bits_reg == rx_need - 4'h1)) begin
								rx_sh_reg <= {rxd, rx_sh_reg[8:1]};
							end
						end
					end
				end
			end
		end
	end
endmodule

// [design/dsp_top.sv]
// dual buffered serial port with switch sampling and stop/resume flow control
//
// Summary of operation
// [R1] buffer both ways; hold off near full
// [R2] power-up: sample switches, enable drivers, idle
// [R3] switches captured at power-up only; software overrides
// [R4] nearly full input sends stop, later resume
// [R5] stop code halts sending until resume code
// [R6] separate enables for stall input, stall output
// [R7] secondary handshake out, polarity from switch
// [R8] default 4800 baud, 7N2, flow off
// [R9] per-port line interface select
// [R10] two ports; address picks port names
// [R11] send only while clear-to-send is on
// [R12] jumper: cts alone or cts and detect
// [R13] reset: txd mark, rts dtr on, handshake off
// [R14] stop 13h, resume 11h, never stored; code stores them while stall_output_en is off
`timescale 1ns/1ps
module dsp_top (
	input  wire logic                          mclk,
	input  wire logic                          srst,
	input  wire logic [1:0][7:0]               line_switches,
	input  wire logic [7:0]                    flow_switch_bank,
	input  wire logic [1:0]                    addr_switches,
	input  wire logic [1:0][1:0]               if_select,
	input  wire logic [1:0]                    cts_and_detect_jumper,
	input  wire logic [1:0]                    sw_override,
	input  wire dsp_pkg::dsp_line_s [1:0]      sw_line,
	input  wire logic [1:0]                    stall_input_en,
	input  wire logic [1:0]                    stall_output_en,
	input  wire logic [1:0]                    rxd,
	input  wire dsp_pkg::dsp_modem_in_s [1:0]  modem_in,
	output logic [1:0]                         txd,
	output logic [1:0]                         rts,
	output logic [1:0]                         dtr,
	output logic [1:0]                         secondary_handshake_out,
	output logic [1:0]                         diff_drv_en,
	output logic [1:0][1:0]                    if_active,
	output logic [1:0]                         first_port_name,
	output logic                               ready,
	input  wire logic [1:0][7:0]               host_tx_data,
	input  wire logic [1:0]                    host_tx_valid,
	output logic [1:0]                         host_tx_ready,
	output logic [1:0][7:0]                    host_rx_data,
	output logic [1:0]                         host_rx_valid,
	input  wire logic [1:0]                    host_rx_ready
);
	import dsp_pkg::*;

	// ----------------------------------------------------------------
	// power-up sequencer
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		DSP_ST_SAMPLE,
		DSP_ST_DRIVERS,
		DSP_ST_IDLE
	} dsp_state_e;

	dsp_state_e   state_reg;
	logic [7:0]   dly_reg;
	logic [1:0][7:0] line_sw_reg;
	logic [7:0]   flow_sw_reg;

	// capture happens once after reset; later switch moves are ignored
	always_ff @(posedge mclk) begin
		if (srst) begin
			state_reg <= DSP_ST_SAMPLE;
			dly_reg   <= '0;
		end else begin
			unique case (state_reg)
				DSP_ST_SAMPLE: begin
					state_reg <= DSP_ST_DRIVERS; // [R2]
					dly_reg   <= DRV_EN_DLY_CYC;
				end
				DSP_ST_DRIVERS: begin
					if (dly_reg == 8'h00) begin
						state_reg <= DSP_ST_IDLE; // [R2]
					end else begin
						dly_reg <= dly_reg - 8'h01;
					end
				end
				DSP_ST_IDLE: begin
					state_reg <= DSP_ST_IDLE;
				end
			endcase
		end
	end

	// switch snapshot, defaults until sampled
	always_ff @(posedge mclk) begin
		if (srst) begin
			line_sw_reg <= {LINE_SW_DEFAULT, LINE_SW_DEFAULT}; // [R8]
			flow_sw_reg <= FLOW_SW_DEFAULT; // [R8]
		end else if (state_reg == DSP_ST_SAMPLE) begin
			line_sw_reg <= line_switches; // [R3]
			flow_sw_reg <= flow_switch_bank; // [R3]
		end
	end

	// port names and readiness
	always_ff @(posedge mclk) begin
		if (srst) begin
			first_port_name <= '0; // [R8]
			ready           <= 1'b0;
		end else begin
			if (state_reg == DSP_ST_SAMPLE) begin
				first_port_name <= addr_switches; // [R10]
			end
			ready <= (state_reg == DSP_ST_IDLE); // [R2]
		end
	end

	// ----------------------------------------------------------------
	// per-port datapath
	// ----------------------------------------------------------------
	genvar p;
	generate
		for (p = 0; p < 2; p++) begin : g_port
			dsp_line_s  line_cur;
			dsp_line_s  line_sw;
			logic [7:0] lsw;
			logic       flow_en;
			logic       flow_pol;
			logic       cts_eff;
			logic       tx_allow;
			logic [7:0] urx_data;
			logic       urx_stb;
			logic       utx_ready;
			logic [7:0] utx_data;
			logic       utx_valid;
			logic       txf_valid;
			logic [7:0] txf_data;
			logic       txf_ready;
			logic [5:0] rx_level;
			logic       rx_in_ready;
			logic       rx_push;
			logic       stopped_reg;
			logic       held_reg;
			logic       send_stop_reg;
			logic       send_resume_reg;
			logic       near_full;
			logic       code_pending;
			logic       txd_w;

			assign lsw      = line_sw_reg[p];
			assign line_sw.ovs_div    = dsp_baud_div(lsw[SW_BAUD_LSB +: 4]);
			assign line_sw.eight_bits = lsw[SW_DBITS_BIT];
			assign line_sw.par_en     = lsw[SW_PAR_LSB + 1];
			assign line_sw.par_odd    = !lsw[SW_PAR_LSB];
			assign line_sw.two_stop   = lsw[SW_STOP_BIT];
			assign line_cur = sw_override[p] ? sw_line[p] : line_sw; // [R3]
			assign flow_en  = flow_sw_reg[p*FSW_PORT_STRIDE + FSW_EN_BIT];
			assign flow_pol = flow_sw_reg[p*FSW_PORT_STRIDE + FSW_POL_BIT];

			// detect jumper lets a busy signal on the secondary detector gate sending
			assign cts_eff  = modem_in[p].cts &&
			                  (!cts_and_detect_jumper[p] || modem_in[p].sec_detect); // [R12]
			assign tx_allow = cts_eff && (state_reg == DSP_ST_IDLE); // [R11]

			// receive buffer: flow codes are consumed, not stored, while stall_output_en is set
			assign rx_push = urx_stb && !(stall_output_en[p] &&
			                 (urx_data == CODE_STOP || urx_data == CODE_RESUME)); // [R14]

			dsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo (
				.mclk      (mclk),
				.srst      (srst),
				.in_data   (urx_data),
				.in_valid  (rx_push),
				.in_ready  (rx_in_ready),
				.out_data  (host_rx_data[p]),
				.out_valid (host_rx_valid[p]),
				.out_ready (host_rx_ready[p]),
				.level     (rx_level)
			);

			// transmit buffer: host stalls on in_ready
			dsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo (
				.mclk      (mclk),
				.srst      (srst),
				.in_data   (host_tx_data[p]),
				.in_valid  (host_tx_valid[p]),
				.in_ready  (host_tx_ready[p]), // [R1]
				.out_data  (txf_data),
				.out_valid (txf_valid),
				.out_ready (txf_ready),
				.level     ()
			);

			assign near_full = rx_level >= NEAR_FULL_LVL; // [R1]

			// stop code from the far end parks data; resume code releases it
			always_ff @(posedge mclk) begin
				if (srst) begin
					stopped_reg <= 1'b0;
				end else if (!stall_output_en[p]) begin
					stopped_reg <= 1'b0; // [R6]
				end else if (urx_stb && urx_data == CODE_STOP) begin
					stopped_reg <= 1'b1; // [R5]
				end else if (urx_stb && urx_data == CODE_RESUME) begin
					stopped_reg <= 1'b0; // [R5]
				end
			end

			// hold-off bookkeeping with hysteresis so codes are not chattered
			always_ff @(posedge mclk) begin
				if (srst) begin
					held_reg        <= 1'b0;
					send_stop_reg   <= 1'b0;
					send_resume_reg <= 1'b0;
				end else begin
					// retire a code the engine takes now; a new request below wins
					if (send_stop_reg && utx_ready && tx_allow) begin
						send_stop_reg <= 1'b0;
					end
					if (send_resume_reg && !send_stop_reg && utx_ready && tx_allow) begin
						send_resume_reg <= 1'b0;
					end
					if (!held_reg && near_full) begin
						held_reg        <= 1'b1; // [R1]
						send_stop_reg   <= stall_input_en[p]; // [R4] [R6]
						send_resume_reg <= 1'b0; // a stale resume must not follow the stop
					end else if (held_reg && rx_level <= RESUME_LVL) begin
						held_reg        <= 1'b0;
						send_resume_reg <= stall_input_en[p]; // [R4]
					end
				end
			end

			// flow codes bypass the stop state, data waits for resume
			assign code_pending = send_stop_reg || send_resume_reg;
			assign utx_data  = send_stop_reg ? CODE_STOP :
			                   send_resume_reg ? CODE_RESUME : txf_data; // [R14]
			assign utx_valid = code_pending || (txf_valid && !stopped_reg); // [R5]
			assign txf_ready = utx_ready && !code_pending && !stopped_reg;

			dsp_uart u_uart (
				.mclk          (mclk),
				.srst          (srst),
				.line          (line_cur),
				.rxd           (rxd[p]),
				.txd_reg       (txd_w),
				.tx_allow      (tx_allow),
				.tx_data       (utx_data),
				.tx_valid      (utx_valid),
				.tx_ready      (utx_ready),
				.rx_data_reg   (urx_data),
				.rx_strobe_reg (urx_stb)
			);

			// pin stage: every output from a flop, reset to power-on levels
			always_ff @(posedge mclk) begin
				if (srst) begin
					txd[p]                     <= 1'b1; // [R13]
					rts[p]                     <= 1'b1; // [R13]
					dtr[p]                     <= 1'b1; // [R13]
					secondary_handshake_out[p] <= 1'b0; // [R13]
					diff_drv_en[p]             <= 1'b0;
					if_active[p]               <= DSP_IF_SINGLE; // [R8]
				end else begin
					txd[p] <= txd_w;
					rts[p] <= 1'b1;
					dtr[p] <= 1'b1;
					// asserted level means "hold off"; polarity picks the sense
					secondary_handshake_out[p] <= flow_en ? (held_reg ~^ flow_pol)
					                                      : 1'b0; // [R7]
					diff_drv_en[p] <= (state_reg != DSP_ST_SAMPLE); // [R2]
					if_active[p]   <= if_select[p]; // [R9]
				end
			end

			// rx_in_ready is not needed: the stop code fires long before full
			logic unused_rx_ready;
			assign unused_rx_ready = rx_in_ready;
		end
	endgenerate
endmodule

// [dv/dsp_top_sva.sv]
// concurrent checks on the dual serial port top level
`timescale 1ns/1ps
module dsp_top_sva (
	input wire logic                         mclk,
	input wire logic                         srst,
	input wire logic [7:0]                   flow_switch_bank,
	input wire logic [1:0][1:0]              if_select,
	input wire logic [1:0]                   stall_output_en,
	input wire dsp_pkg::dsp_modem_in_s [1:0] modem_in,
	input wire logic [1:0]                   txd,
	input wire logic [1:0]                   secondary_handshake_out,
	input wire logic [1:0]                   diff_drv_en,
	input wire logic [1:0][1:0]              if_active,
	input wire logic [1:0]                   first_port_name,
	input wire logic                         ready,
	input wire logic [1:0][7:0]              host_rx_data,
	input wire logic [1:0]                   host_rx_valid
);
	import dsp_pkg::*;
	// one frame at the fastest bench rate fits well inside this span
	localparam int FRAME_MAX = 400;
	int unsigned gate0_lo;
	int unsigned gate1_lo;

	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	// cycles for which each port's transmit gate has been shut, saturating
	always_ff @(posedge mclk) begin
		if (srst || modem_in[0].cts)
			gate0_lo <= 0;
		else if (gate0_lo < 1000)
			gate0_lo <= gate0_lo + 1;
	end
	always_ff @(posedge mclk) begin
		if (srst || (modem_in[1].cts && modem_in[1].sec_detect))
			gate1_lo <= 0;
		else if (gate1_lo < 1000)
			gate1_lo <= gate1_lo + 1;
	end

	a_ready_after_drv: assert property ($rose(diff_drv_en[0]) |-> !ready ##[1:40] ready)
		else $error("ready not raised after drivers");
	a_ready_holds: assert property (ready |=> ready)
		else $error("ready dropped");
	a_idle_mark: assert property (!ready |-> txd == 2'b11)
		else $error("txd left mark before ready");
	a_name_locked: assert property (ready |=> $stable(first_port_name))
		else $error("port name changed after power-up");
	a_if_follow: assert property (!$past(srst) |-> if_active == $past(if_select))
		else $error("interface select not followed");
	a_flow_off: assert property (!flow_switch_bank[4] |-> secondary_handshake_out[1] == 1'b0)
		else $error("handshake driven while flow off");
	a_cts_gate: assert property (gate0_lo > FRAME_MAX |-> txd[0])
		else $error("sent while clear-to-send off");
	a_detect_gate: assert property (gate1_lo > FRAME_MAX |-> txd[1])
		else $error("sent while detect off with jumper");
	a_codes_hidden: assert property (host_rx_valid[0] && stall_output_en[0]
		|-> host_rx_data[0] != CODE_STOP && host_rx_data[0] != CODE_RESUME)
		else $error("flow code stored as data");
endmodule

bind dsp_top dsp_top_sva dsp_top_sva_inst (.mclk(mclk), .srst(srst),
	.flow_switch_bank(flow_switch_bank), .if_select(if_select),
	.stall_output_en(stall_output_en), .modem_in(modem_in), .txd(txd),
	.secondary_handshake_out(secondary_handshake_out), .diff_drv_en(diff_drv_en),
	.if_active(if_active), .first_port_name(first_port_name), .ready(ready),
	.host_rx_data(host_rx_data), .host_rx_valid(host_rx_valid));

// [dv/dsp_term.sv]
// serial terminal model standing on the far side of one port
`timescale 1ns/1ps
module dsp_term #(
	parameter int BIT = 32
) (
	input wire logic mclk,
	input wire logic txd,
	output logic     rxd
);
	logic [7:0] got_q[$];
	logic       held;
	logic [7:0] b;

	initial begin
		rxd = 1'b1;
		held = 1'b0;
	end

	// take frames from the port; mid-bit sampling, eight data samples
	always begin
		@(negedge txd);
		repeat (BIT / 2) @(posedge mclk);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT) @(posedge mclk);
			b[i] = txd;
		end
		repeat (BIT / 2) @(posedge mclk);
		got_q.push_back(b);
		if (b == 8'h13) held = 1'b1;
		if (b == 8'h11) held = 1'b0;
	end

	// a held terminal waits, but never cuts a frame short
	task automatic send(input logic [7:0] d);
		while (held) @(negedge mclk);
		@(negedge mclk);
		rxd = 1'b0;
		repeat (BIT) @(negedge mclk);
		for (int i = 0; i < 8; i++) begin
			rxd = d[i];
			repeat (BIT) @(negedge mclk);
		end
		rxd = 1'b1;
		repeat (BIT) @(negedge mclk);
	endtask
endmodule

// [dv/dsp_top_test.sv]
// self-checking bench for the dual serial port block
`timescale 1ns/1ps
module dsp_top_test;
	import dsp_pkg::*;
	// 16x oversample with divider 2 gives 32 clocks a bit, short runs
	localparam dsp_line_s LINE_FAST = '{16'h0002, 1'b1, 1'b0, 1'b0, 1'b0};
	logic                mclk, srst, ready;
	logic [1:0][7:0]     line_switches, host_tx_data, host_rx_data;
	logic [7:0]          flow_switch_bank;
	logic [1:0]          addr_switches, cts_and_detect_jumper, sw_override, stall_input_en;
	logic [1:0]          stall_output_en, rxd, txd, rts, dtr, secondary_handshake_out;
	logic [1:0]          diff_drv_en, first_port_name, host_tx_valid, host_tx_ready;
	logic [1:0]          host_rx_valid, host_rx_ready;
	logic [1:0][1:0]     if_select, if_active;
	dsp_line_s [1:0]     sw_line;
	dsp_modem_in_s [1:0] modem_in;
	int                  fails, compares, rx_cnt;

	dsp_top dsp_top_inst (.*);
	dsp_term #(.BIT(32)) term_inst (.mclk(mclk), .txd(txd[0]), .rxd(rxd[0]));
	assign rxd[1] = 1'b1;

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end

	// count words the host takes from port 0
	always @(posedge mclk) begin
		if (host_rx_valid[0] === 1'b1 && host_rx_ready[0] === 1'b1) rx_cnt++;
	end

	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			fails++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic print_verdict;
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	task automatic wait_got(input int n);
		for (int k = 0; k < 20000 && term_inst.got_q.size() < n; k++) @(negedge mclk);
	endtask

	// request held until the edge that samples ready high
	task automatic host_send(input logic [7:0] d);
		int n;
		@(negedge mclk);
		host_tx_data[0] = d;
		host_tx_valid[0] = 1'b1;
		n = 0;
		// ready is looked at between edges, so the next rising edge takes the word
		while (host_tx_ready[0] !== 1'b1 && n < 2000) begin
			@(negedge mclk);
			n++;
		end
		@(negedge mclk);
		host_tx_valid[0] = 1'b0;
	endtask

	task automatic t_reset;
		repeat (20) @(negedge mclk);
		chk("txd", 8'h03, 8'(txd));
		chk("rts dtr", 8'h0f, 8'({rts, dtr}));
		chk("handshake ready", 8'h00, 8'({secondary_handshake_out, ready}));
		srst = 1'b0;
		for (int i = 0; i < 100 && ready !== 1'b1; i++) @(negedge mclk);
		chk("ready", 8'h01, 8'(ready));
		chk("drivers", 8'h03, 8'(diff_drv_en));
		chk("port name", 8'h01, 8'(first_port_name));
		$display("test reset done");
	endtask

	task automatic t_locked;
		addr_switches = 2'h2;
		line_switches = {8'h0f, 8'h0f};
		repeat (5) @(negedge mclk);
		chk("port name", 8'h01, 8'(first_port_name));
		$display("test locked done");
	endtask

	task automatic t_iface;
		for (int m = 0; m < 3; m++) begin
			if_select = {2'(m), 2'(2 - m)};
			repeat (2) @(negedge mclk);
			chk("if active", 8'({2'(m), 2'(2 - m)}), 8'(if_active));
		end
		$display("test iface done");
	endtask

	task automatic t_tx;
		host_send(8'ha5);
		host_send(8'h3c);
		wait_got(2);
		chk("tx first", 8'ha5, term_inst.got_q[0]);
		chk("tx second", 8'h3c, term_inst.got_q[1]);
		sw_line[0].eight_bits = 1'b0;
		host_send(8'h45);
		wait_got(3);
		chk("tx seven bit", 8'hc5, term_inst.got_q[2]);
		repeat (100) @(negedge mclk);
		sw_line[0].eight_bits = 1'b1;
		$display("test tx done");
	endtask

	task automatic t_stop;
		int n0;
		stall_output_en[0] = 1'b1;
		term_inst.send(CODE_STOP);
		n0 = term_inst.got_q.size();
		host_send(8'h77);
		repeat (600) @(negedge mclk);
		chk("held count", 8'(n0), 8'(term_inst.got_q.size()));
		term_inst.send(CODE_RESUME);
		wait_got(n0 + 1);
		chk("resumed", 8'h77, term_inst.got_q[n0]);
		term_inst.send(8'h5a);
		for (int k = 0; k < 200 && host_rx_valid[0] !== 1'b1; k++) @(negedge mclk);
		chk("rx data", 8'h5a, host_rx_data[0]);
		host_rx_ready[0] = 1'b1;
		@(negedge mclk);
		host_rx_ready[0] = 1'b0;
		$display("test stop done");
	endtask

	task automatic t_flow;
		int n0;
		int c0;
		stall_input_en[0] = 1'b1;
		n0 = term_inst.got_q.size();
		c0 = rx_cnt;
		fork
			for (int i = 0; i < 26; i++) term_inst.send(8'(i + 32));
		join_none
		wait_got(n0 + 1);
		chk("stop code", CODE_STOP, term_inst.got_q[n0]);
		chk("handshake", 8'h01, 8'(secondary_handshake_out[0]));
		host_rx_ready[0] = 1'b1;
		wait_got(n0 + 2);
		chk("resume code", CODE_RESUME, term_inst.got_q[n0 + 1]);
		chk("handshake", 8'h00, 8'(secondary_handshake_out[0]));
		wait fork;
		repeat (400) @(negedge mclk);
		chk("drained", 8'd26, 8'(rx_cnt - c0));
		host_rx_ready[0] = 1'b0;
		$display("test flow done");
	endtask

	task automatic t_cts;
		int n0;
		modem_in[0].cts = 1'b0;
		n0 = term_inst.got_q.size();
		// port 1 fifo is empty, so its word is taken at the next rising edge
		host_tx_data[1] = 8'h55;
		host_tx_valid[1] = 1'b1;
		@(negedge mclk);
		host_tx_valid[1] = 1'b0;
		host_send(8'h66);
		repeat (500) @(negedge mclk);
		chk("gated count", 8'(n0), 8'(term_inst.got_q.size()));
		chk("detect gated", 8'h01, 8'(txd[1]));
		modem_in[0].cts = 1'b1;
		wait_got(n0 + 1);
		chk("after cts", 8'h66, term_inst.got_q[n0]);
		modem_in[1].sec_detect = 1'b1;
		repeat (8) @(negedge mclk);
		chk("detect open", 8'h00, 8'(txd[1]));
		$display("test cts done");
	endtask

	// port 1 starts with its detect line low so the jumper gate stays shut until t_cts raises it
	initial begin
		srst = 1'b1;
		line_switches = {LINE_SW_DEFAULT, LINE_SW_DEFAULT};
		flow_switch_bank = 8'h03;
		addr_switches = 2'h1;
		if_select = {2'h1, 2'h1};
		cts_and_detect_jumper = 2'b10;
		sw_override = 2'b11;
		sw_line = {LINE_FAST, LINE_FAST};
		stall_input_en = 2'b00;
		stall_output_en = 2'b00;
		modem_in = {2'b10, 2'b11};
		host_tx_data = '0;
		host_tx_valid = 2'b00;
		host_rx_ready = 2'b00;
		fails = 0;
		compares = 0;
		rx_cnt = 0;
		t_reset;
		t_locked;
		t_iface;
		t_tx;
		t_stop;
		t_flow;
		t_cts;
		print_verdict;
	end

	// the tests need about 13000 cycles; give three times that
	initial begin
		repeat (40000) @(posedge mclk);
		fails++;
		print_verdict;
	end
endmodule
